// ---- cfd_decoder.sv ----
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module cfd_decoder #(
    parameter int DEPTH = 64
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output var  logic [31:0] reg_rdata,
    // command frame
    input  wire logic        cmd_valid,
    input  wire logic [1:0]  cmd_kind,
    input  wire logic [7:0]  cmd_p1,
    input  wire logic [7:0]  cmd_p2,
    input  wire logic [7:0]  cmd_lc,
    input  wire logic [7:0]  cmd_le,
    output var  logic        cmd_ready,
    // update data stream
    input  wire logic        data_in_valid,
    input  wire logic [7:0]  data_in,
    output var  logic        data_in_ready,
    // response stream and completion
    output var  logic        resp_valid,
    output var  logic [7:0]  resp_byte,
    output var  logic        resp_last,
    output var  logic        cmd_done,
    output var  logic        cmd_error,
    output var  logic [2:0]  error_code,
    output var  logic [1:0]  status_kind,
    output var  logic [1:0]  app_indication
);
    localparam int ADDR_W = $clog2(DEPTH);
    localparam logic [16:0] DEPTH17 = 17'(DEPTH);

    typedef struct packed {
        cfd_pkg::cfd_state_t        st;
        logic [1:0]                 fstruct;
        logic                       read_ok;
        logic                       update_ok;
        logic [4:0]                 file_sfi;
        logic [7:0]                 rec_len;
        logic [7:0]                 rec_count;
        logic [7:0]                 rec_ptr;
        logic                       ptr_valid;
        logic [1:0]                 app_ind;
        logic [2:0]                 last_err;
        logic [ADDR_W-1:0]          mem_addr;
        logic [16:0]                pos;
        logic [8:0]                 remain;
        logic [31:0]                rdata;
        logic                       cmd_ready;
        logic                       data_ready;
        logic                       resp_valid;
        logic [7:0]                 resp_byte;
        logic                       resp_last;
        logic                       done;
        logic                       err;
        logic [2:0]                 err_code;
        logic [1:0]                 status_kind;
        logic [DEPTH-1:0][7:0]      mem;
    } cfd_regs_t;

    cfd_regs_t r;
    cfd_regs_t next_r;

    // expected length of zero stands for the full 256 bytes
    function automatic logic [8:0] le_count(input logic [7:0] le);
        le_count = (le == 8'h00) ? 9'h100 : {1'b0, le};
    endfunction : le_count

    function automatic cfd_pkg::cfd_bin_addr_t bin_addr(input logic [7:0] p1, input logic [7:0] p2);
        cfd_pkg::cfd_bin_addr_t a;
        a = '0;
        if (!p1[7]) begin
            a.offset = {p1[6:0], p2};
        end else if (p1[7:5] == cfd_pkg::BIN_SFI_MARK) begin
            a.short_file_id    = p1[4:0];
            a.offset = {7'h00, p2};
        end else begin
            a.bad = 1'b1;
        end
        return a;
    endfunction : bin_addr

    // a short id that is neither zero nor this file's id names a file we do not hold
    function automatic logic sfi_miss(input logic [4:0] short_file_id, input logic [4:0] own);
        sfi_miss = (short_file_id != cfd_pkg::SFI_CURRENT) && (short_file_id != own);
    endfunction : sfi_miss

    cfd_pkg::cfd_bin_addr_t ba;
    logic [16:0] bin_end;
    logic [16:0] rec_start;
    logic [16:0] rec_end;
    logic [7:0]  target;
    logic [7:0]  new_ptr;
    logic        move_ptr;
    logic [2:0]  rej;

    always_comb begin
        next_r = r;
        ba = bin_addr(cmd_p1, cmd_p2);
        bin_end = '0;
        rec_start = '0;
        rec_end = '0;
        target = 8'h00;
        new_ptr = r.rec_ptr;
        move_ptr = 1'b0;
        rej = cfd_pkg::ERR_NONE;
        next_r.done = 1'b0;
        next_r.err = 1'b0;
        next_r.resp_valid = 1'b0;
        next_r.resp_last = 1'b0;
        next_r.rdata = 32'h0000_0000;

        // register port; memory window writes only while idle so commands own the array
        if (reg_write) begin
            case (reg_addr)
                cfd_pkg::REG_FILE_CFG: begin
                    next_r.fstruct = reg_wdata[cfd_pkg::FILE_CFG_STRUCT_LSB +: 2];
                    next_r.read_ok = reg_wdata[cfd_pkg::FILE_CFG_READ_OK];
                    next_r.update_ok = reg_wdata[cfd_pkg::FILE_CFG_UPDATE_OK];
                    next_r.file_sfi = reg_wdata[cfd_pkg::FILE_CFG_SFI_LSB +: 5];
                    // a new file selection forgets the record pointer
                    next_r.ptr_valid = 1'b0;
                end
                cfd_pkg::REG_REC_CFG: begin
                    next_r.rec_len = reg_wdata[cfd_pkg::REC_CFG_LEN_LSB +: 8];
                    next_r.rec_count = reg_wdata[cfd_pkg::REC_CFG_COUNT_LSB +: 8];
                end
                cfd_pkg::REG_MEM_ADDR: begin
                    next_r.mem_addr = reg_wdata[ADDR_W-1:0];
                end
                cfd_pkg::REG_MEM_DATA: begin
                    if (r.st == cfd_pkg::CFD_IDLE) begin
                        next_r.mem[r.mem_addr] = reg_wdata[7:0];
                        next_r.mem_addr = r.mem_addr + 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (reg_read) begin
            case (reg_addr)
                cfd_pkg::REG_FILE_CFG: next_r.rdata = {23'h0, r.file_sfi, r.update_ok, r.read_ok, r.fstruct};
                cfd_pkg::REG_REC_CFG:  next_r.rdata = {16'h0, r.rec_count, r.rec_len};
                cfd_pkg::REG_STATE:    next_r.rdata = {14'h0, r.st, 2'h0, r.last_err, r.app_ind, r.ptr_valid, r.rec_ptr};
                cfd_pkg::REG_MEM_ADDR: next_r.rdata = 32'(r.mem_addr);
                cfd_pkg::REG_MEM_DATA: next_r.rdata = {24'h0, r.mem[r.mem_addr]};
                default:               next_r.rdata = 32'h0000_0000;
            endcase
        end

        case (r.st)
            cfd_pkg::CFD_IDLE: begin
                if (cmd_valid) begin
                    case (cmd_kind)
                        cfd_pkg::CFD_CMD_STATUS: begin
                            // expected length plays no part; the caller trims the answer
                            if (cmd_p1 != cfd_pkg::ST_P1_NONE && cmd_p1 != cfd_pkg::ST_P1_INIT &&
                                cmd_p1 != cfd_pkg::ST_P1_TERM) begin
                                rej = cfd_pkg::ERR_PARAM;
                            end else if (cmd_p2 == cfd_pkg::ST_P2_SELECT) begin
                                next_r.status_kind = cfd_pkg::KIND_SELECT;
                            end else if (cmd_p2 == cfd_pkg::ST_P2_APP_NAME) begin
                                next_r.status_kind = cfd_pkg::KIND_APP_NAME;
                            end else if (cmd_p2 == cfd_pkg::ST_P2_NO_DATA) begin
                                next_r.status_kind = cfd_pkg::KIND_NO_DATA;
                            end else begin
                                rej = cfd_pkg::ERR_PARAM;
                            end
                            if (rej == cfd_pkg::ERR_NONE) begin
                                next_r.app_ind = cmd_p1[1:0];
                                next_r.done = 1'b1;
                            end else begin
                                next_r.status_kind = r.status_kind;
                            end
                        end
                        cfd_pkg::CFD_CMD_READ_BIN, cfd_pkg::CFD_CMD_UPDATE_BIN: begin
                            bin_end = {2'b00, ba.offset} + ((cmd_kind == cfd_pkg::CFD_CMD_READ_BIN) ?
                                      {8'h00, le_count(cmd_le)} : {9'h000, cmd_lc});
                            if (ba.bad) begin
                                rej = cfd_pkg::ERR_PARAM;
                            end else if (sfi_miss(ba.short_file_id, r.file_sfi)) begin
                                rej = cfd_pkg::ERR_NOT_FOUND;
                            end else if (r.fstruct != cfd_pkg::FS_TRANSPARENT) begin
                                rej = cfd_pkg::ERR_TYPE;
                            end else if (cmd_kind == cfd_pkg::CFD_CMD_READ_BIN && !r.read_ok) begin
                                rej = cfd_pkg::ERR_ACCESS;
                            end else if (cmd_kind == cfd_pkg::CFD_CMD_UPDATE_BIN && !r.update_ok) begin
                                rej = cfd_pkg::ERR_ACCESS;
                            end else if (cmd_kind == cfd_pkg::CFD_CMD_UPDATE_BIN && cmd_lc == 8'h00) begin
                                rej = cfd_pkg::ERR_PARAM;
                            end else if (bin_end > DEPTH17) begin
                                rej = cfd_pkg::ERR_RANGE;
                            end
                            if (rej == cfd_pkg::ERR_NONE) begin
                                next_r.pos = {2'b00, ba.offset};
                                if (cmd_kind == cfd_pkg::CFD_CMD_READ_BIN) begin
                                    next_r.remain = le_count(cmd_le);
                                    next_r.st = cfd_pkg::CFD_READ;
                                end else begin
                                    next_r.remain = {1'b0, cmd_lc};
                                    next_r.st = cfd_pkg::CFD_WRITE;
                                end
                            end
                        end
                        default: begin
                            // record read; the first parameter is ignored in next and previous modes
                            if (cmd_p2[7:3] == cfd_pkg::SFI_RESERVED) begin
                                rej = cfd_pkg::ERR_PARAM;
                            end else if (cmd_p2[2:0] != cfd_pkg::MODE_NEXT && cmd_p2[2:0] != cfd_pkg::MODE_PREV &&
                                         cmd_p2[2:0] != cfd_pkg::MODE_ABS) begin
                                rej = cfd_pkg::ERR_PARAM;
                            end else if (sfi_miss(cmd_p2[7:3], r.file_sfi)) begin
                                rej = cfd_pkg::ERR_NOT_FOUND;
                            end else if (r.fstruct != cfd_pkg::FS_LINEAR && r.fstruct != cfd_pkg::FS_CYCLIC) begin
                                rej = cfd_pkg::ERR_TYPE;
                            end else if (!r.read_ok) begin
                                rej = cfd_pkg::ERR_ACCESS;
                            end else if (le_count(cmd_le) != {1'b0, r.rec_len} || r.rec_count == 8'h00) begin
                                rej = cfd_pkg::ERR_RANGE;
                            end else begin
                                case (cmd_p2[2:0])
                                    cfd_pkg::MODE_NEXT: begin
                                        move_ptr = 1'b1;
                                        if (!r.ptr_valid) begin
                                            target = 8'h01;
                                        end else if (r.rec_ptr >= r.rec_count) begin
                                            if (r.fstruct == cfd_pkg::FS_CYCLIC) begin
                                                target = 8'h01;
                                            end else begin
                                                rej = cfd_pkg::ERR_NO_RECORD;
                                            end
                                        end else begin
                                            target = r.rec_ptr + 8'h01;
                                        end
                                    end
                                    cfd_pkg::MODE_PREV: begin
                                        move_ptr = 1'b1;
                                        if (!r.ptr_valid) begin
                                            target = r.rec_count;
                                        end else if (r.rec_ptr <= 8'h01) begin
                                            if (r.fstruct == cfd_pkg::FS_CYCLIC) begin
                                                target = r.rec_count;
                                            end else begin
                                                rej = cfd_pkg::ERR_NO_RECORD;
                                            end
                                        end else begin
                                            target = r.rec_ptr - 8'h01;
                                        end
                                    end
                                    default: begin
                                        if (cmd_p1 == 8'h00) begin
                                            target = r.rec_ptr;
                                            if (!r.ptr_valid) begin
                                                rej = cfd_pkg::ERR_NO_RECORD;
                                            end
                                        end else if (cmd_p1 > r.rec_count) begin
                                            rej = cfd_pkg::ERR_NO_RECORD;
                                        end else begin
                                            target = cmd_p1;
                                        end
                                    end
                                endcase
                            end
                            rec_start = {1'b0, 16'((target - 8'h01) * r.rec_len)};
                            rec_end = rec_start + {9'h000, r.rec_len};
                            if (rej == cfd_pkg::ERR_NONE && rec_end > DEPTH17) begin
                                rej = cfd_pkg::ERR_RANGE;
                            end
                            if (rej == cfd_pkg::ERR_NONE) begin
                                if (move_ptr) begin
                                    new_ptr = target;
                                    next_r.ptr_valid = 1'b1;
                                end
                                next_r.rec_ptr = new_ptr;
                                next_r.pos = rec_start;
                                next_r.remain = {1'b0, r.rec_len};
                                next_r.st = cfd_pkg::CFD_READ;
                            end
                        end
                    endcase
                    if (rej != cfd_pkg::ERR_NONE) begin
                        next_r.err = 1'b1;
                        next_r.done = 1'b1;
                    end
                    next_r.err_code = rej;
                    next_r.last_err = rej;
                end
            end
            cfd_pkg::CFD_READ: begin
                next_r.resp_valid = 1'b1;
                next_r.resp_byte = r.mem[r.pos[ADDR_W-1:0]];
                next_r.pos = r.pos + 17'h00001;
                next_r.remain = r.remain - 9'h001;
                if (r.remain == 9'h001) begin
                    next_r.resp_last = 1'b1;
                    next_r.done = 1'b1;
                    next_r.st = cfd_pkg::CFD_IDLE;
                end
            end
            cfd_pkg::CFD_WRITE: begin
                if (data_in_valid) begin
                    next_r.mem[r.pos[ADDR_W-1:0]] = data_in;
                    next_r.pos = r.pos + 17'h00001;
                    next_r.remain = r.remain - 9'h001;
                    if (r.remain == 9'h001) begin
                        next_r.done = 1'b1;
                        next_r.st = cfd_pkg::CFD_IDLE;
                    end
                end
            end
            default: begin
                next_r.st = cfd_pkg::CFD_IDLE;
            end
        endcase
        // ready flags follow the state being entered so they match it cycle for cycle
        next_r.cmd_ready = (next_r.st == cfd_pkg::CFD_IDLE);
        next_r.data_ready = (next_r.st == cfd_pkg::CFD_WRITE);
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
            r.st <= cfd_pkg::CFD_IDLE;
            r.fstruct <= cfd_pkg::RST_STRUCT;
            r.file_sfi <= cfd_pkg::RST_FILE_SFI;
            r.rec_len <= cfd_pkg::RST_REC_LEN;
            r.rec_count <= cfd_pkg::RST_REC_COUNT;
            r.cmd_ready <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign cmd_ready = r.cmd_ready;
    assign data_in_ready = r.data_ready;
    assign resp_valid = r.resp_valid;
    assign resp_byte = r.resp_byte;
    assign resp_last = r.resp_last;
    assign cmd_done = r.done;
    assign cmd_error = r.err;
    assign error_code = r.err_code;
    assign status_kind = r.status_kind;
    assign app_indication = r.app_ind;
endmodule : cfd_decoder
`default_nettype wire

// ---- cfd_pkg.sv ----
`default_nettype none
package cfd_pkg;
    // command kinds presented on cmd_kind
    typedef enum logic [1:0] {
        CFD_CMD_STATUS      = 2'b00,
        CFD_CMD_READ_BIN    = 2'b01,
        CFD_CMD_UPDATE_BIN  = 2'b10,
        CFD_CMD_READ_REC    = 2'b11
    } cfd_cmd_t;

    typedef enum logic [1:0] {
        CFD_IDLE  = 2'b00,
        CFD_READ  = 2'b01,
        CFD_WRITE = 2'b10
    } cfd_state_t;

    // file structures
    localparam logic [1:0] FS_TRANSPARENT = 2'h0;
    localparam logic [1:0] FS_LINEAR      = 2'h1;
    localparam logic [1:0] FS_CYCLIC      = 2'h2;

    // reject codes
    localparam logic [2:0] ERR_NONE      = 3'h0;
    localparam logic [2:0] ERR_PARAM     = 3'h1;
    localparam logic [2:0] ERR_ACCESS    = 3'h2;
    localparam logic [2:0] ERR_TYPE      = 3'h3;
    localparam logic [2:0] ERR_RANGE     = 3'h4;
    localparam logic [2:0] ERR_NO_RECORD = 3'h5;
    localparam logic [2:0] ERR_NOT_FOUND = 3'h6;

    // status command parameter values
    localparam logic [7:0] ST_P1_NONE      = 8'h00;
    localparam logic [7:0] ST_P1_INIT      = 8'h01;
    localparam logic [7:0] ST_P1_TERM      = 8'h02;
    localparam logic [7:0] ST_P2_SELECT    = 8'h00;
    localparam logic [7:0] ST_P2_APP_NAME  = 8'h01;
    localparam logic [7:0] ST_P2_NO_DATA   = 8'h0C;
    localparam logic [1:0] KIND_SELECT     = 2'h0;
    localparam logic [1:0] KIND_APP_NAME   = 2'h1;
    localparam logic [1:0] KIND_NO_DATA    = 2'h2;

    // record read mode field in the second parameter low bits, short file id values and the binary id mark
    localparam logic [2:0] MODE_NEXT     = 3'b010;
    localparam logic [2:0] MODE_PREV     = 3'b011;
    localparam logic [2:0] MODE_ABS      = 3'b100;
    localparam logic [4:0] SFI_CURRENT   = 5'h00;
    localparam logic [4:0] SFI_RESERVED  = 5'h1F;
    localparam logic [2:0] BIN_SFI_MARK  = 3'b100;

    // register byte offsets
    localparam logic [7:0] REG_FILE_CFG = 8'h00;
    localparam logic [7:0] REG_REC_CFG  = 8'h04;
    localparam logic [7:0] REG_STATE    = 8'h08;
    localparam logic [7:0] REG_MEM_ADDR = 8'h0C;
    localparam logic [7:0] REG_MEM_DATA = 8'h10;

    // field positions
    localparam int FILE_CFG_STRUCT_LSB = 0;
    localparam int FILE_CFG_READ_OK    = 2;
    localparam int FILE_CFG_UPDATE_OK  = 3;
    localparam int FILE_CFG_SFI_LSB    = 4;
    localparam int REC_CFG_LEN_LSB     = 0;
    localparam int REC_CFG_COUNT_LSB   = 8;

    // reset values
    localparam logic [1:0] RST_STRUCT    = FS_TRANSPARENT;
    localparam logic [4:0] RST_FILE_SFI  = 5'h01;
    localparam logic [7:0] RST_REC_LEN   = 8'h00;
    localparam logic [7:0] RST_REC_COUNT = 8'h00;

    typedef struct packed {
        logic        bad;
        logic [4:0]  short_file_id;
        logic [14:0] offset;
    } cfd_bin_addr_t;
endpackage : cfd_pkg
`default_nettype wire

// ---- cfd_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfd_properties (
    // watched ports
    input wire logic       clock, reset_n, cmd_valid, cmd_ready,
    input wire logic [1:0] cmd_kind, status_kind, app_indication,
    input wire logic [7:0] cmd_p1, cmd_p2,
    input wire logic       resp_valid, resp_last, cmd_done, cmd_error,
    input wire logic [2:0] error_code
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    wire st = cmd_valid && cmd_ready && cmd_kind == 2'h0;
    wire rb = cmd_valid && cmd_ready && cmd_kind == 2'h1;
    wire rr = cmd_valid && cmd_ready && cmd_kind == 2'h3;
    st_p1_a: assert property (st && cmd_p1 > 8'h02 |=> cmd_error && error_code == cfd_pkg::ERR_PARAM)
        else $error("status p1 not refused");
    st_nodata_a: assert property (st && cmd_p1 == 8'h02 && cmd_p2 == 8'h0C |=>
        cmd_done && !cmd_error && status_kind == 2'h2 && app_indication == 2'h2) else $error("status no data");
    st_p2_a: assert property (st && !(cmd_p2 inside {8'h00, 8'h01, 8'h0C}) |=> cmd_error)
        else $error("status p2 not refused");
    bin_code_a: assert property (rb && cmd_p1[7] && cmd_p1[6:5] != 2'h0 |=> cmd_error)
        else $error("binary p1 not refused");
    rec_mode_a: assert property (rr && !(cmd_p2[2:0] inside {3'h2, 3'h3, 3'h4}) |=>
        cmd_error && error_code == cfd_pkg::ERR_PARAM) else $error("record mode not refused");
    rec_id_a: assert property (rr && cmd_p2[7:3] == 5'h1F |=> cmd_error) else $error("id 31 taken");
    last_done_a: assert property (resp_last |-> resp_valid && cmd_done && !cmd_error)
        else $error("last byte without done");
    resp_busy_a: assert property (resp_valid |-> cmd_ready == resp_last) else $error("ready while answering");
    err_done_a: assert property (cmd_error |-> cmd_done && error_code != 3'h0)
        else $error("reject without done");
endmodule : cfd_properties
`default_nettype wire

// ---- cfd_terminal.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfd_terminal (
    // clock
    input  wire logic       clock,
    // command frame
    output var  logic       cmd_valid,
    output var  logic [1:0] cmd_kind,
    output var  logic [7:0] cmd_p1, cmd_p2, cmd_lc, cmd_le,
    input  wire logic       cmd_ready,
    // update data
    output var  logic       data_in_valid,
    output var  logic [7:0] data_in,
    input  wire logic       data_in_ready,
    // answer
    input  wire logic       resp_valid, cmd_done, cmd_error,
    input  wire logic [7:0] resp_byte,
    input  wire logic [2:0] error_code
);
    logic [7:0] rx [256];
    int         n_rx, i;
    logic       err, to;
    logic [2:0] code;
    initial {cmd_valid, cmd_kind, cmd_p1, cmd_p2, cmd_lc, cmd_le, data_in_valid, data_in} = '0;
    // caller keeps lc zero off update, le unused on update, p1 zero in next/previous
    task send(input logic [1:0] k, input logic [7:0] p1, p2, lc, le, base);
        n_rx = 0;
        i = 0;
        to = 1'b1;
        @(posedge clock);
        {cmd_valid, cmd_kind, cmd_p1, cmd_p2, cmd_lc, cmd_le} <= {1'b1, k, p1, p2, lc, le};
        // hold the request until ready is seen at an edge; a lost command then shows up as a timeout
        for (int w = 0; w < 600; w++) begin
            @(posedge clock);
            if (cmd_ready) break;
        end
        cmd_valid <= 1'b0;
        for (int c = 0; c < 600 && to; c++) begin
            @(posedge clock);
            if (data_in_valid && data_in_ready) i++;
            data_in_valid <= data_in_ready && i < lc;
            // idle data toggles so a stale byte is never mistaken for a fresh one
            data_in <= (data_in_ready && i < lc) ? base + 8'(i) : ~data_in;
            if (resp_valid) rx[n_rx++] = resp_byte;
            if (cmd_done) {to, err, code} = {1'b0, cmd_error, error_code};
        end
    endtask : send
endmodule : cfd_terminal
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; $display("Error t=%0t %h %h", $time, a, b); end end
module tb_top;
    logic        clock = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0]  reg_addr = 8'h00, cmd_p1, cmd_p2, cmd_lc, cmd_le, data_in, resp_byte;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic        cmd_valid, cmd_ready, data_in_valid, data_in_ready, resp_valid, resp_last, cmd_done, cmd_error;
    logic [1:0]  cmd_kind, status_kind, app_indication;
    logic [2:0]  error_code;
    int          err_total = 0, n_checks = 0;
    always #10 clock = ~clock;
    // deep storage so a seven-bit high offset lands inside the file
    cfd_decoder #(.DEPTH(512)) i_dut (.clock, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .cmd_valid, .cmd_kind, .cmd_p1, .cmd_p2, .cmd_lc, .cmd_le, .cmd_ready, .data_in_valid, .data_in,
        .data_in_ready, .resp_valid, .resp_byte, .resp_last, .cmd_done, .cmd_error, .error_code, .status_kind,
        .app_indication);
    cfd_terminal i_term (.clock, .cmd_valid, .cmd_kind, .cmd_p1, .cmd_p2, .cmd_lc, .cmd_le, .cmd_ready,
        .data_in_valid, .data_in, .data_in_ready, .resp_valid, .cmd_done, .cmd_error, .resp_byte, .error_code);
    task final_report;
        if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        {reg_write, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        {reg_read, reg_addr} <= {1'b1, a};
        @(posedge clock);
        reg_read <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask : rd
    task cmd(input logic [1:0] k, input logic [7:0] p1, p2, lc, le, input logic [2:0] e);
        i_term.send(k, p1, p2, lc, le, 8'hA0);
        if (i_term.to) begin err_total++; final_report(); end
        `CHK(i_term.code, e)
    endtask : cmd
    task rec(input logic [7:0] p1, p2, input int n);
        cmd(2'h3, p1, p2, 8'h00, 8'h02, n ? 3'h0 : 3'h5);
        `CHK(i_term.n_rx, n ? 2 : 0)
        if (n) `CHK({i_term.rx[0], i_term.rx[1]}, {8'h3E + 8'(2 * n), 8'h3F + 8'(2 * n)})
    endtask : rec
    task t_status;
        for (int p = 0; p < 3; p++) begin
            cmd(2'h0, 8'(p), 8'h0C, 8'h00, 8'h00, 3'h0);
            `CHK({status_kind, app_indication}, {2'h2, 2'(p)})
        end
        cmd(2'h0, 8'h01, 8'h01, 8'h00, 8'hFF, 3'h0);
        `CHK(status_kind, 2'h1)
        cmd(2'h0, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0);
        `CHK(status_kind, 2'h0)
        cmd(2'h0, 8'h03, 8'h00, 8'h00, 8'h00, 3'h1);
        cmd(2'h0, 8'h02, 8'h08, 8'h00, 8'h00, 3'h1);
        `CHK(app_indication, 2'h0)
    endtask : t_status
    task t_bin;
        cmd(2'h1, 8'h00, 8'h05, 8'h00, 8'h01, 3'h2);
        wr(8'h00, 32'h1C);
        cmd(2'h2, 8'h01, 8'h05, 8'h03, 8'h00, 3'h0);
        cmd(2'h1, 8'h01, 8'h06, 8'h00, 8'h02, 3'h0);
        `CHK({i_term.rx[0], i_term.rx[1], 8'(i_term.n_rx)}, {8'hA1, 8'hA2, 8'h02})
        cmd(2'h1, 8'h82, 8'h05, 8'h00, 8'h01, 3'h6);
        cmd(2'h1, 8'hA0, 8'h05, 8'h00, 8'h01, 3'h1);
        cmd(2'h2, 8'h00, 8'h05, 8'h00, 8'h00, 3'h1);
        cmd(2'h3, 8'h01, 8'h04, 8'h00, 8'h02, 3'h3);
        wr(8'h00, 32'h14);
        cmd(2'h2, 8'h00, 8'h05, 8'h01, 8'h00, 3'h2);
        cmd(2'h1, 8'h81, 8'h05, 8'h00, 8'h01, 3'h0);
        `CHK(i_term.rx[0], 8'h00)
    endtask : t_bin
    task t_rec;
        wr(8'h0C, 32'h0);
        for (int j = 0; j < 6; j++) wr(8'h10, 32'h40 + j);
        wr(8'h04, 32'h0302);
        wr(8'h00, 32'h11);
        cmd(2'h3, 8'h01, 8'h04, 8'h00, 8'h02, 3'h2);
        wr(8'h00, 32'h15);
        rec(8'h00, 8'h04, 0);
        rec(8'h00, 8'h03, 3);
        rec(8'h00, 8'h0A, 0);
        rec(8'h01, 8'h04, 1);
        rec(8'h00, 8'h04, 3);
        rec(8'h00, 8'h03, 2);
        rec(8'h00, 8'h02, 3);
        cmd(2'h3, 8'h00, 8'h07, 8'h00, 8'h02, 3'h1);
        cmd(2'h3, 8'h00, 8'hFC, 8'h00, 8'h02, 3'h1);
        cmd(2'h3, 8'h00, 8'h02, 8'h00, 8'h03, 3'h4);
        rec(8'h04, 8'h04, 0);
        rec(8'h00, 8'h04, 3);
        rec(8'h00, 8'h03, 2);
        rec(8'h00, 8'h03, 1);
        rec(8'h00, 8'h03, 0);
        wr(8'h00, 32'h16);
        rec(8'h00, 8'h02, 1);
        rec(8'h00, 8'h03, 3);
        rec(8'h00, 8'h02, 1);
    endtask : t_rec
    initial begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        rd(8'h00, 32'h10);
        rd(8'h08, 32'h0);
        rd(8'hFC, 32'h0);
        t_status();
        t_bin();
        t_rec();
        final_report();
    end
endmodule : tb_top
bind cfd_decoder cfd_properties i_prop (.clock, .reset_n, .cmd_valid, .cmd_ready, .cmd_kind, .status_kind,
    .app_indication, .cmd_p1, .cmd_p2, .resp_valid, .resp_last, .cmd_done, .cmd_error, .error_code);
`default_nettype wire
